/* File: common/i2c_status_pkg.sv */
`default_nettype none
package i2c_status_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] OFS_STATUS = 8'h1a;
  localparam logic [7:0] OFS_SYNC_BUSY = 8'h1c;
  localparam logic [7:0] OFS_DATA = 8'h18;
  localparam logic [7:0] OFS_ADDRESS = 8'h24;

  // ==========================================================
  // Status field positions
  localparam int POS_BUS_ERROR = 0;
  localparam int POS_ARB_LOST = 1;
  localparam int POS_RX_NACK = 2;
  localparam int POS_STATE_LO = 4;
  localparam int POS_LOW_TIMEOUT = 6;

  // ==========================================================
  // Sync busy field positions
  localparam int POS_BUSY_SOFT_RESET = 0;
  localparam int POS_BUSY_ENABLE = 1;
  localparam int POS_BUSY_SYSTEM_OPERATION_BUSY = 2;

  // ==========================================================
  // Address register field positions
  localparam int POS_ADDR_HI = 10;
  localparam int POS_LEN_EN = 13;
  localparam int POS_HIGH_SPEED = 14;
  localparam int POS_TEN_BIT = 15;
  localparam int POS_LEN_LO = 16;
  localparam int POS_LEN_HI = 23;

  // ==========================================================
  // Bus state field codes
  localparam logic [1:0] CODE_UNKNOWN = 2'h0;
  localparam logic [1:0] CODE_IDLE = 2'h1;
  localparam logic [1:0] CODE_OWNER = 2'h2;
  localparam logic [1:0] CODE_BUSY = 2'h3;

  // ==========================================================
  // Cycle counts and reset values
  localparam logic [3:0] SYNC_CYCLES = 4'h3;
  localparam int SCL_LOW_TIMEOUT_CYCLES = 1000;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [3:0] {
    BS_UNKNOWN = 4'h1,
    BS_IDLE = 4'h2,
    BS_OWNER = 4'h4,
    BS_BUSY = 4'h8
  } bus_state_t;

endpackage : i2c_status_pkg
`default_nettype wire

/* File: logic/i2c_line_monitor.sv */
`default_nettype none
module i2c_line_monitor #(
  parameter int TIMEOUT_CYCLES = i2c_status_pkg::SCL_LOW_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Bus lines
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Detected conditions
  output logic start_seen,
  output logic stop_seen,
  output logic violation,
  output logic scl_timeout
);

  generate
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 65535) begin : g_chk
      $error("TIMEOUT_CYCLES out of range");
    end
  endgenerate

  localparam logic [15:0] TOUT = 16'(TIMEOUT_CYCLES);

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic armed;
    logic [15:0] low_cnt;
    logic start_seen;
    logic stop_seen;
    logic violation;
    logic scl_timeout;
  } mon_t;

  mon_t s;
  mon_t next_s;

  // ==========================================================
  // Condition detection
  always_comb begin
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], scl_pin};
    next_s.sda_sync = {s.sda_sync[0], sda_pin};
    next_s.scl_prev = s.scl_sync[1];
    next_s.sda_prev = s.sda_sync[1];
    next_s.start_seen = s.scl_sync[1] && s.scl_prev && s.sda_prev && !s.sda_sync[1];
    next_s.stop_seen = s.scl_sync[1] && s.scl_prev && !s.sda_prev && s.sda_sync[1];
    next_s.violation = 1'b0;
    next_s.scl_timeout = 1'b0;
    // Start followed by stop with no clock pulse between
    if (next_s.start_seen) begin
      next_s.armed = 1'b1;
    end else if (s.scl_prev && !s.scl_sync[1]) begin
      next_s.armed = 1'b0;
    end else if (next_s.stop_seen) begin
      next_s.violation = s.armed;
      next_s.armed = 1'b0;
    end
    if (s.scl_sync[1]) begin
      next_s.low_cnt = 16'h0000;
    end else if (s.low_cnt != TOUT) begin
      next_s.low_cnt = s.low_cnt + 16'h0001;
      next_s.scl_timeout = (s.low_cnt + 16'h0001) == TOUT;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign start_seen = s.start_seen;
  assign stop_seen = s.stop_seen;
  assign violation = s.violation;
  assign scl_timeout = s.scl_timeout;

endmodule : i2c_line_monitor
`default_nettype wire

/* File: logic/i2c_master_status.sv */
// How it works
// - Timeout sets the low-timeout flag; one written or address write clears it.
// - Bus-state field codes: 0 unknown, 1 idle, 2 owner, 3 busy.
// - Bus state reads unknown while disabled and right after enabling.
// - Unknown state leaves only on a stop, a software force or lost arbitration.
// - Writing 1 to the field while unknown forces idle; other values ignored.
// - Forcing idle raises system-operation busy until it has crossed over.
// - Received-NACK shows last acknowledge; writes do nothing.
// - Lost arbitration sets arbitration-lost and pulses master-on-bus set.
// - Arbitration-lost clears on address write or one written.
// - Start directly followed by stop sets bus error.
// - Timeout within a frame sets bus error.
// - Bus error while owner also sets arbitration-lost and master-on-bus.
// - Bus error clears on address write or one written.
// - Enabled writes to control B, address, data, and a state write that forces idle, raise system busy.
// - Enable change raises enable busy; writes then refused with error.
// - Soft reset raises reset busy; all writes then refused with error.
// - With length enabled, after that many bytes request an automatic stop.
// - Ten-bit bit selects ten-bit addressing.
// - High-speed bit selects high-speed for the transfer.
// - Length-enable bit switches automatic length on.
// - Address write acts by state: abort, wait, start or repeated start.
// - Address bit zero is the read/write direction.
`default_nettype none
module i2c_master_status #(
  parameter int TIMEOUT_CYCLES = i2c_status_pkg::SCL_LOW_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ready,
  output logic reg_error,
  // Unit control
  input wire logic enable_in,
  input wire logic soft_reset,
  input wire logic control_register_b_write,
  // Bus lines
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Bit engine events
  input wire logic arb_lost_event,
  input wire logic ack_event,
  input wire logic ack_was_nack,
  input wire logic byte_done,
  // Requests to bit engine
  output logic start_request,
  output logic repeated_start_request,
  output logic auto_stop_request,
  output logic master_on_bus_set,
  output logic [10:0] target_address,
  output logic read_transfer,
  output logic ten_bit_enable,
  output logic high_speed_enable,
  output logic length_enable,
  output logic [7:0] transfer_length,
  output logic unit_enabled
);

  typedef struct packed {
    i2c_status_pkg::bus_state_t bstate;
    logic enabled, en_target;
    logic scl_low_timeout_flag, received_nack_bit, arbitration_lost_flag, bus_error_flag;
    logic [10:0] addr;
    logic ten_bit, high_speed, len_en;
    logic [7:0] len;
    logic [7:0] byte_count;
    logic pend_start, own_start, pend_force;
    logic [3:0] system_operation_busy_cnt, enable_cnt, soft_reset_cnt;
    logic start_req, rstart_req, auto_end, mb_set;
    logic [31:0] rdata;
    logic ready, error;
  } state_t;

  localparam state_t RESET_STATE = '{bstate: i2c_status_pkg::BS_UNKNOWN, default: '0};

  state_t s;
  state_t next_s;

  logic start_seen, stop_seen, violation, scl_timeout;

  i2c_line_monitor #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_monitor (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .violation(violation),
    .scl_timeout(scl_timeout)
  );

  function automatic logic [1:0] state_code(input i2c_status_pkg::bus_state_t st);
    unique case (st)
      i2c_status_pkg::BS_UNKNOWN: state_code = i2c_status_pkg::CODE_UNKNOWN;
      i2c_status_pkg::BS_IDLE: state_code = i2c_status_pkg::CODE_IDLE;
      i2c_status_pkg::BS_OWNER: state_code = i2c_status_pkg::CODE_OWNER;
      i2c_status_pkg::BS_BUSY: state_code = i2c_status_pkg::CODE_BUSY;
      default: state_code = i2c_status_pkg::CODE_UNKNOWN;
    endcase
  endfunction : state_code

  logic busy_enable, busy_reset, write_ok, addr_write, status_write, in_frame;

  assign busy_enable = s.enable_cnt != 4'h0;
  assign busy_reset = s.soft_reset_cnt != 4'h0;
  assign write_ok = reg_write && !busy_enable && !busy_reset;
  assign addr_write = write_ok && reg_addr == i2c_status_pkg::OFS_ADDRESS;
  assign status_write = write_ok && reg_addr == i2c_status_pkg::OFS_STATUS;
  assign in_frame = s.bstate == i2c_status_pkg::BS_OWNER || s.bstate == i2c_status_pkg::BS_BUSY;

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.start_req = 1'b0;
    next_s.rstart_req = 1'b0;
    next_s.auto_end = 1'b0;
    next_s.mb_set = 1'b0;
    next_s.ready = reg_write || reg_read;
    next_s.error = reg_write && (busy_enable || busy_reset);
    next_s.rdata = i2c_status_pkg::RESET_WORD;
    if (reg_read) begin
      unique case (reg_addr)
        i2c_status_pkg::OFS_STATUS: begin
          next_s.rdata[i2c_status_pkg::POS_LOW_TIMEOUT] = s.scl_low_timeout_flag;
          next_s.rdata[i2c_status_pkg::POS_STATE_LO +: 2] = state_code(s.bstate);
          next_s.rdata[i2c_status_pkg::POS_RX_NACK] = s.received_nack_bit;
          next_s.rdata[i2c_status_pkg::POS_ARB_LOST] = s.arbitration_lost_flag;
          next_s.rdata[i2c_status_pkg::POS_BUS_ERROR] = s.bus_error_flag;
        end
        i2c_status_pkg::OFS_SYNC_BUSY: begin
          next_s.rdata[i2c_status_pkg::POS_BUSY_SOFT_RESET] = busy_reset;
          next_s.rdata[i2c_status_pkg::POS_BUSY_ENABLE] = busy_enable;
          next_s.rdata[i2c_status_pkg::POS_BUSY_SYSTEM_OPERATION_BUSY] = s.system_operation_busy_cnt != 4'h0;
        end
        i2c_status_pkg::OFS_ADDRESS: begin
          next_s.rdata[i2c_status_pkg::POS_ADDR_HI:0] = s.addr;
          next_s.rdata[i2c_status_pkg::POS_LEN_EN] = s.len_en;
          next_s.rdata[i2c_status_pkg::POS_HIGH_SPEED] = s.high_speed;
          next_s.rdata[i2c_status_pkg::POS_TEN_BIT] = s.ten_bit;
          next_s.rdata[i2c_status_pkg::POS_LEN_HI:i2c_status_pkg::POS_LEN_LO] = s.len;
        end
        default: next_s.rdata = i2c_status_pkg::RESET_WORD;
      endcase
    end

    // Synchronisation counters
    if (s.system_operation_busy_cnt != 4'h0) next_s.system_operation_busy_cnt = s.system_operation_busy_cnt - 4'h1;
    if (s.enable_cnt != 4'h0) next_s.enable_cnt = s.enable_cnt - 4'h1;
    if (s.soft_reset_cnt != 4'h0) next_s.soft_reset_cnt = s.soft_reset_cnt - 4'h1;
    if (soft_reset && !busy_reset) begin
      next_s.soft_reset_cnt = i2c_status_pkg::SYNC_CYCLES;
    end
    if (enable_in != s.enabled && !busy_enable && !busy_reset) begin
      next_s.enable_cnt = i2c_status_pkg::SYNC_CYCLES;
      next_s.en_target = enable_in;
    end
    if (s.enable_cnt == 4'h1) begin
      next_s.enabled = s.en_target;
      next_s.bstate = i2c_status_pkg::BS_UNKNOWN;
    end

    // Software clears first, so hardware sets below win
    if (status_write) begin
      if (reg_wdata[i2c_status_pkg::POS_LOW_TIMEOUT]) next_s.scl_low_timeout_flag = 1'b0;
      if (reg_wdata[i2c_status_pkg::POS_ARB_LOST]) next_s.arbitration_lost_flag = 1'b0;
      if (reg_wdata[i2c_status_pkg::POS_BUS_ERROR]) next_s.bus_error_flag = 1'b0;
      if (s.enabled && s.bstate == i2c_status_pkg::BS_UNKNOWN &&
          reg_wdata[i2c_status_pkg::POS_STATE_LO +: 2] == i2c_status_pkg::CODE_IDLE) begin
        next_s.pend_force = 1'b1;
        next_s.system_operation_busy_cnt = i2c_status_pkg::SYNC_CYCLES;
      end
    end
    if (s.enabled && (control_register_b_write ||
        (write_ok && reg_addr == i2c_status_pkg::OFS_DATA))) begin
      next_s.system_operation_busy_cnt = i2c_status_pkg::SYNC_CYCLES;
    end
    if (addr_write) begin
      next_s.addr = reg_wdata[i2c_status_pkg::POS_ADDR_HI:0];
      next_s.len_en = reg_wdata[i2c_status_pkg::POS_LEN_EN];
      next_s.high_speed = reg_wdata[i2c_status_pkg::POS_HIGH_SPEED];
      next_s.ten_bit = reg_wdata[i2c_status_pkg::POS_TEN_BIT];
      next_s.len = reg_wdata[i2c_status_pkg::POS_LEN_HI:i2c_status_pkg::POS_LEN_LO];
      next_s.byte_count = 8'h00;
      next_s.scl_low_timeout_flag = 1'b0;
      next_s.arbitration_lost_flag = 1'b0;
      next_s.bus_error_flag = 1'b0;
      next_s.pend_start = 1'b0;
      if (s.enabled) begin
        next_s.system_operation_busy_cnt = i2c_status_pkg::SYNC_CYCLES;
        unique case (s.bstate)
          i2c_status_pkg::BS_UNKNOWN: begin
            next_s.bus_error_flag = 1'b1;
            next_s.mb_set = 1'b1;
          end
          i2c_status_pkg::BS_BUSY: next_s.pend_start = 1'b1;
          i2c_status_pkg::BS_IDLE: begin
            next_s.start_req = 1'b1;
            next_s.own_start = 1'b1;
          end
          i2c_status_pkg::BS_OWNER: next_s.rstart_req = 1'b1;
          default: next_s.bus_error_flag = 1'b1;
        endcase
      end
    end

    // Bus state tracking
    if (s.enabled && s.enable_cnt == 4'h0) begin
      if (s.pend_force && s.system_operation_busy_cnt == 4'h1 && s.bstate == i2c_status_pkg::BS_UNKNOWN) begin
        next_s.bstate = i2c_status_pkg::BS_IDLE;
        next_s.pend_force = 1'b0;
      end
      if (stop_seen) begin
        next_s.bstate = i2c_status_pkg::BS_IDLE;
        next_s.pend_force = 1'b0;
      end else if (start_seen && s.bstate == i2c_status_pkg::BS_IDLE) begin
        next_s.bstate = s.own_start ? i2c_status_pkg::BS_OWNER : i2c_status_pkg::BS_BUSY;
        next_s.own_start = 1'b0;
      end
      if (s.bstate == i2c_status_pkg::BS_IDLE && s.pend_start && !addr_write) begin
        next_s.pend_start = 1'b0;
        next_s.start_req = 1'b1;
        next_s.own_start = 1'b1;
      end
      if (arb_lost_event) begin
        next_s.arbitration_lost_flag = 1'b1;
        next_s.mb_set = 1'b1;
        next_s.bstate = i2c_status_pkg::BS_BUSY;
      end
      if (violation || (scl_timeout && in_frame)) begin
        next_s.bus_error_flag = 1'b1;
        if (s.bstate == i2c_status_pkg::BS_OWNER) begin
          next_s.arbitration_lost_flag = 1'b1;
          next_s.mb_set = 1'b1;
        end
      end
      if (scl_timeout) next_s.scl_low_timeout_flag = 1'b1;
      if (ack_event) next_s.received_nack_bit = ack_was_nack;
      if (byte_done) begin
        next_s.byte_count = s.byte_count + 8'h01;
        next_s.auto_end = s.len_en && (s.byte_count + 8'h01) == s.len;
      end
    end
    if (!next_s.enabled) begin
      next_s.bstate = i2c_status_pkg::BS_UNKNOWN;
      next_s.pend_start = 1'b0;
      next_s.own_start = 1'b0;
      next_s.pend_force = 1'b0;
    end

    // Soft reset lands once it has crossed; ready and error are kept, read data is cleared
    if (s.soft_reset_cnt == 4'h1) begin
      next_s = RESET_STATE;
      next_s.ready = reg_write || reg_read;
      next_s.error = reg_write;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign reg_ready = s.ready;
  assign reg_error = s.error;
  assign start_request = s.start_req;
  assign repeated_start_request = s.rstart_req;
  assign auto_stop_request = s.auto_end;
  assign master_on_bus_set = s.mb_set;
  assign target_address = s.addr;
  assign read_transfer = s.addr[0];
  assign ten_bit_enable = s.ten_bit;
  assign high_speed_enable = s.high_speed;
  assign length_enable = s.len_en;
  assign transfer_length = s.len;
  assign unit_enabled = s.enabled;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic run;
  assign run = s.enabled && s.enable_cnt == 4'h0 && s.soft_reset_cnt != 4'h1;

  scl_low_timeout_flag_set_a: assert property (run && scl_timeout |=> s.scl_low_timeout_flag)
    else $error("low timeout flag not set");
  disabled_unknown_a: assert property (!s.enabled |-> s.bstate == i2c_status_pkg::BS_UNKNOWN)
    else $error("state not unknown while disabled");
  force_idle_a: assert property (run && status_write &&
      s.bstate == i2c_status_pkg::BS_UNKNOWN &&
      reg_wdata[5:4] == 2'h1 && enable_in && !soft_reset
      |=> s.system_operation_busy_cnt != 4'h0 ##[1:3] s.bstate == i2c_status_pkg::BS_IDLE)
    else $error("force to idle did not complete");
  system_operation_busy_busy_a: assert property (run && addr_write |=> s.system_operation_busy_cnt == i2c_status_pkg::SYNC_CYCLES)
    else $error("address write did not raise busy");
  enable_refuse_a: assert property (reg_write && busy_enable |=> s.error && s.ready)
    else $error("write during enable sync not refused");
  reset_refuse_a: assert property (reg_write && busy_reset |=> s.error)
    else $error("write during reset sync not refused");
  arb_lost_a: assert property (run && arb_lost_event |=> s.arbitration_lost_flag && s.mb_set)
    else $error("arbitration loss not flagged");
  owner_error_a: assert property (run && s.bstate == i2c_status_pkg::BS_OWNER &&
      (violation || (scl_timeout && in_frame))
      |=> s.bus_error_flag && s.arbitration_lost_flag && s.mb_set)
    else $error("bus error as owner not flagged");
  unknown_addr_a: assert property (run && addr_write &&
      s.bstate == i2c_status_pkg::BS_UNKNOWN
      |=> s.bus_error_flag && s.mb_set && !s.start_req)
    else $error("address write in unknown state not aborted");
  auto_end_a: assert property (run && byte_done && s.len_en && s.byte_count + 8'h01 == s.len
      |=> s.auto_end)
    else $error("automatic stop not requested");

  idle_start_c: cover property (s.start_req ##[1:200] s.bstate == i2c_status_pkg::BS_OWNER);
  force_idle_c: cover property (s.pend_force ##[1:5] s.bstate == i2c_status_pkg::BS_IDLE);
  bus_error_c: cover property (s.bus_error_flag && s.arbitration_lost_flag);

endmodule : i2c_master_status
`default_nettype wire

/* File: sim/i2c_bus_partner.sv */
`default_nettype none
module i2c_bus_partner (
  // Bus lines
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Open-drain lines rest high through pull-ups
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // ==========================================
  // Conditions, clocked at an 80 ns bit period
  task automatic start_cond();
    sda = 1'b0;
    #40 scl = 1'b0;
  endtask : start_cond

  // Clock back up with data still low, keeping the frame open
  task automatic hold_high();
    #40 scl = 1'b1;
  endtask : hold_high

  task automatic bits(input int n);
    repeat (n) begin
      #40 scl = 1'b1;
      #40 scl = 1'b0;
    end
  endtask : bits

  // Low clock first so the data fall is no start
  task automatic stop_cond();
    scl = 1'b0;
    #40 sda = 1'b0;
    #40 scl = 1'b1;
    #40 sda = 1'b1;
  endtask : stop_cond

  // Start directly followed by stop with no clock fall
  task automatic glitch();
    sda = 1'b0;
    #40 sda = 1'b1;
  endtask : glitch
endmodule : i2c_bus_partner
`default_nettype wire

/* File: sim/i2c_master_status_bench.sv */
`default_nettype none
module i2c_master_status_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Set-up
  localparam int TMO = 20;
  localparam logic [7:0] ST = i2c_status_pkg::OFS_STATUS;
  localparam logic [7:0] SB = i2c_status_pkg::OFS_SYNC_BUSY;
  localparam logic [7:0] AD = i2c_status_pkg::OFS_ADDRESS;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic err;
  } note_t;
  note_t notes[$];
  note_t n;
  int checked = 0;
  int fails = 0;
  int cnt_start = 0;
  int cnt_stop = 0;
  int cnt_mb = 0;
  int cnt_rstart = 0;
  logic [31:0] r;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic enable_in = 1'b0;
  logic soft_reset = 1'b0;
  logic cb_write = 1'b0;
  logic arb_lost_event = 1'b0;
  logic ack_event = 1'b0;
  logic ack_was_nack = 1'b0;
  logic byte_done = 1'b0;
  logic [31:0] reg_rdata;
  logic reg_ready, reg_error, start_request, auto_stop_request, master_on_bus_set;
  logic repeated_start_request;
  logic [10:0] target_address;
  logic read_transfer, ten_bit_enable, high_speed_enable, length_enable, unit_enabled;
  logic [7:0] transfer_length;
  wire logic scl_line;
  wire logic sda_line;

  always #5 clk_sys = ~clk_sys;

  i2c_master_status #(.TIMEOUT_CYCLES(TMO)) i2c_master_status_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ready(reg_ready), .reg_error(reg_error), .enable_in(enable_in),
    .soft_reset(soft_reset), .control_register_b_write(cb_write),
    .scl_pin(scl_line), .sda_pin(sda_line), .arb_lost_event(arb_lost_event),
    .ack_event(ack_event), .ack_was_nack(ack_was_nack), .byte_done(byte_done),
    .start_request(start_request), .repeated_start_request(repeated_start_request),
    .auto_stop_request(auto_stop_request), .master_on_bus_set(master_on_bus_set),
    .target_address(target_address), .read_transfer(read_transfer),
    .ten_bit_enable(ten_bit_enable), .high_speed_enable(high_speed_enable),
    .length_enable(length_enable), .transfer_length(transfer_length),
    .unit_enabled(unit_enabled));

  i2c_bus_partner i2c_bus_partner_inst (.scl(scl_line), .sda(sda_line));

  // ==========================================
  // Checking
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // Oldest note is matched against each answer
  always @(negedge clk_sys) begin
    if (start_request === 1'b1) cnt_start++;
    if (repeated_start_request === 1'b1) cnt_rstart++;
    if (auto_stop_request === 1'b1) cnt_stop++;
    if (master_on_bus_set === 1'b1) cnt_mb++;
    if (reg_ready === 1'b1) begin
      if (notes.size() == 0) begin
        chk("reg_ready", 32'h0, 32'h1);
      end else begin
        n = notes.pop_front();
        chk("reg_rdata", n.data, reg_rdata & n.mask);
        chk("reg_error", {31'h0, n.err}, {31'h0, reg_error});
      end
    end
  end

  // ==========================================
  // Drivers
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic er);
    @(negedge clk_sys);
    reg_write = w;
    reg_read = ~w;
    reg_addr = a;
    reg_wdata = d;
    notes.push_back('{e, m, er});
    @(negedge clk_sys);
    reg_write = 1'b0;
    reg_read = 1'b0;
  endtask : acc

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask : pulse

  task automatic gap(input int c);
    repeat (c) @(negedge clk_sys);
  endtask : gap

  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(45626));
    gap(12);
    rst_b = 1'b1;
    acc(0, ST, 0, 0, 32'h77, 0);
    acc(0, AD, 0, 0, '1, 0);
    acc(0, 8'h40, 0, 0, '1, 0);
    acc(1, 8'h40, '1, 0, 0, 0);
    enable_in = 1'b1;
    acc(0, SB, 0, 32'h2, 32'h7, 0);
    gap(6);
    chk("unit_enabled", 1, {31'h0, unit_enabled});
    acc(0, ST, 0, 0, 32'h77, 0);
    r = $urandom;
    acc(1, AD, r, 0, 0, 0);
    gap(4);
    chk("mb after abort", 1, cnt_mb);
    chk("no start in unknown", 0, cnt_start);
    acc(0, ST, 0, 32'h1, 32'h31, 0);
    acc(1, ST, 32'h20, 0, 0, 0);
    acc(1, ST, 32'h0, 0, 0, 0);
    acc(0, ST, 0, 32'h1, 32'h31, 0);
    acc(1, ST, 32'h1, 0, 0, 0);
    acc(0, ST, 0, 0, 32'h1, 0);
    acc(1, ST, 32'h10, 0, 0, 0);
    acc(0, SB, 0, 32'h4, 32'h7, 0);
    gap(6);
    acc(0, ST, 0, 32'h10, 32'h30, 0);
    pulse(cb_write);
    acc(0, SB, 0, 32'h4, 32'h7, 0);
    gap(6);
    r = $urandom;
    r[31:16] = 16'h0002;
    r[13] = 1'b1;
    r[12:11] = 2'b00;
    acc(1, AD, r, 0, 0, 0);
    acc(0, SB, 0, 32'h4, 32'h7, 0);
    chk("start", 1, cnt_start);
    chk("fields", {18'h0, r[15:13], r[10:0]}, {18'h0, ten_bit_enable, high_speed_enable,
        length_enable, target_address});
    chk("direction", {31'h0, r[0]}, {31'h0, read_transfer});
    chk("length", 32'h2, {24'h0, transfer_length});
    acc(0, AD, 0, r, 32'h00ffe7ff, 0);
    pulse(byte_done);
    gap(2);
    chk("early stop", 0, cnt_stop);
    pulse(byte_done);
    gap(2);
    chk("auto stop", 1, cnt_stop);
    ack_was_nack = 1'b1;
    pulse(ack_event);
    acc(1, ST, 32'h4, 0, 0, 0);
    acc(0, ST, 0, 32'h4, 32'h4, 0);
    ack_was_nack = 1'b0;
    pulse(ack_event);
    acc(0, ST, 0, 0, 32'h4, 0);
    pulse(arb_lost_event);
    gap(2);
    chk("mb after loss", 2, cnt_mb);
    acc(1, ST, 32'h0, 0, 0, 0);
    acc(0, ST, 0, 32'h32, 32'h33, 0);
    acc(1, AD, r, 0, 0, 0);
    acc(0, ST, 0, 0, 32'h3, 0);
    i2c_bus_partner_inst.stop_cond();
    gap(10);
    chk("start after idle", 2, cnt_start);
    i2c_bus_partner_inst.start_cond();
    i2c_bus_partner_inst.hold_high();
    gap(6);
    acc(0, ST, 0, 32'h20, 32'h30, 0);
    acc(1, AD, r, 0, 0, 0);
    gap(2);
    chk("repeated start", 1, cnt_rstart);
    i2c_bus_partner_inst.bits(1);
    #400;
    i2c_bus_partner_inst.stop_cond();
    gap(10);
    acc(0, ST, 0, 32'h53, 32'h77, 0);
    chk("mb as owner", 3, cnt_mb);
    pulse(soft_reset);
    acc(1, ST, 32'h1, 0, 0, 1);
    gap(12);
    acc(0, ST, 0, 0, 32'h77, 0);
    i2c_bus_partner_inst.stop_cond();
    gap(10);
    acc(0, ST, 0, 32'h10, 32'h30, 0);
    i2c_bus_partner_inst.start_cond();
    i2c_bus_partner_inst.bits(2);
    #400;
    i2c_bus_partner_inst.stop_cond();
    gap(10);
    acc(0, ST, 0, 32'h41, 32'h41, 0);
    acc(1, ST, 32'h41, 0, 0, 0);
    acc(0, ST, 0, 0, 32'h41, 0);
    i2c_bus_partner_inst.glitch();
    gap(10);
    acc(0, ST, 0, 32'h1, 32'h1, 0);
    enable_in = 1'b0;
    acc(1, ST, 32'h1, 0, 0, 1);
    gap(8);
    acc(0, ST, 0, 32'h1, 32'h31, 0);
    for (int i = 0; i < 20 && notes.size() != 0; i++) @(negedge clk_sys);
    if (notes.size() != 0) fails++;
    complete_run();
  end
endmodule : i2c_master_status_bench
`default_nettype wire
